// ==== logic/eta_consts.svh ====
/*
 * Constants of the embedded trigger acquisition controller: sizes,
 * register offsets, control bit positions, reset values and post-trigger fill percentages.
 * Assumes inclusion by bare name from the package, the checker and the testbench.
 */
`ifndef ETA_CONSTS_SVH
`define ETA_CONSTS_SVH

`define ETA_DEPTH 64
`define ETA_AW 6
`define ETA_PW 8
`define ETA_LEVELS 4
`define ETA_BUS_AW 4
`define ETA_BUS_DW 32

`define ETA_REG_CTRL 4'h0
`define ETA_REG_CFG 4'h1
`define ETA_REG_CMP_LO 4'h2
`define ETA_REG_CMP_HI 4'h3
`define ETA_REG_SEG 4'h4
`define ETA_REG_STATUS 4'h5
`define ETA_REG_DATA 4'h6
`define ETA_REG_COND0 4'h8

`define ETA_COND_TRIG_IN 4
`define ETA_COND_QUAL 5
`define ETA_COND_PLAIN 6
`define ETA_NCOND 7

`define ETA_CTRL_START 0
`define ETA_CTRL_FORCE 1
`define ETA_CTRL_ABORT 2

`define ETA_CFG_W 14
`define ETA_CFG_RST 14'h0000
`define ETA_COND_RST 16'h0000
`define ETA_SEG_M_RST 8'h04
`define ETA_SEG_N_RST 8'h10

`define ETA_POST_PCT_LO 12
`define ETA_POST_PCT_MID 50
`define ETA_POST_PCT_HI 88

`endif

// ==== logic/eta_pkg.sv ====
/*
 * Types of the embedded trigger acquisition controller.
 * Assumes eta_consts.svh on the include path.
 */
`include "eta_consts.svh"

package eta_pkg;

    typedef enum logic [3:0] {
        PH_READY = 4'h0,
        PH_WAIT_CLK = 4'h1,
        PH_PRE_FILL = 4'h2,
        PH_TRIG_IN = 4'h3,
        PH_WAIT_TRIG = 4'h4,
        PH_POST = 4'h5,
        PH_SEG_PLAIN = 4'h6,
        PH_SEG_ARM = 4'h7,
        PH_SEG_COUNT = 4'h8,
        PH_SEG_FINAL = 4'h9,
        PH_OFFLOAD = 4'hA
    } phase_t;

    typedef enum logic [1:0] {
        MATCH_AND = 2'h0,
        MATCH_OR = 2'h1,
        MATCH_CMP = 2'h2
    } match_mode_t;

    typedef struct packed {
        logic [`ETA_PW-1:0] mask;
        logic [`ETA_PW-1:0] value;
    } cond_t;

    typedef struct packed {
        match_mode_t match_mode;
        // Spare bit keeps the match field at the top of the word
        logic rsvd;
        logic power_up;
        logic segmented_path_flag;
        logic plain_path_flag;
        logic [1:0] levels_m1;
        logic trig_in_en;
        logic [1:0] post_sel;
        logic qual_disable;
        logic qual_en;
        logic segmented;
    } cfg_t;

endpackage

// ==== logic/embedded_trigger_acquisition_controller.sv ====
/*
 * Embedded logic-analyzer acquisition controller: samples probed signals
 * on edges of the sampling clock into an on-chip buffer, sequences through
 * the acquisition phases and offloads over the host register port.
 * Assumes the host port is driven on sys_clk_i and that sampling clock
 * and probes are asynchronous and much slower than sys_clk_i.
 */
// The register offsets and the plain strobed port were chosen for this implementation.
// Notes on behaviour
// - Triggered capture kept in memory for readout
// - Forced trigger offloads current buffer contents
// - Basic trigger and qualifier values run-time loadable
// - Comparison bounds loadable; switch to basic OR
// - Qualifier-disable setting forces continuous capture
// - Arming state: store, count segment, or final
// - Sample-count state counts n then re-arms
// - Segment limits m and n writable
// - Status flags enable plain or segmented paths
// - Report waiting-for-clock until sampling edge seen
// - Continuous non-segmented: fill buffer before triggering
// - Trigger-in condition awaited before first level
// - Trigger levels strictly in order, reported
// - Post-trigger fill of 12, 50 or 88 percent
// - Offload phase shown while host reads data
// - Idle ready until host starts analysis
// - Segmented mode skips pre-fill and post fraction
// - Power-up runs same phases, flagged as such
// - Qualified or segmented: trigger evaluated at once
`timescale 1ns/100ps

module embedded_trigger_acquisition_controller
    import eta_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic samp_clk_i,
    input wire logic [`ETA_PW-1:0] probe_i,
    input wire logic [`ETA_BUS_AW-1:0] addr_i,
    input wire logic [`ETA_BUS_DW-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`ETA_BUS_DW-1:0] rd_data_o,
    output logic [3:0] phase_o,
    output logic offload_o,
    output logic waiting_clk_o
);

    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic [`ETA_PW-1:0] prb_s1;
        logic [`ETA_PW-1:0] prb_s2;
        cfg_t cfg;
        logic [`ETA_NCOND-1:0][15:0] cond;
        logic [`ETA_PW-1:0] cmp_lo;
        logic [`ETA_PW-1:0] cmp_hi;
        logic [7:0] seg_m;
        logic [7:0] seg_n;
        phase_t phase;
        logic pu;
        logic [1:0] lvl;
        logic [2:0] last_level;
        logic [`ETA_AW-1:0] wptr;
        logic full;
        logic [`ETA_AW:0] fill;
        logic [7:0] post_cnt;
        logic [7:0] post_tgt;
        logic [7:0] segment_counter;
        logic [7:0] per_segment_sample_counter;
        logic [`ETA_AW-1:0] rd_ptr;
        logic [`ETA_AW:0] rd_left;
        logic [`ETA_DEPTH-1:0][`ETA_PW-1:0] mem;
        logic [`ETA_BUS_DW-1:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Basic AND, basic OR over masked bits, or interval compare
    function automatic logic cond_hit(input logic [15:0] c, input match_mode_t mode,
                                      input logic [`ETA_PW-1:0] p, input logic [`ETA_PW-1:0] lo,
                                      input logic [`ETA_PW-1:0] hi);
        cond_t cc;
        logic hit;
        cc = cond_t'(c);
        case (mode)
            MATCH_AND: hit = ((p ^ cc.value) & cc.mask) == '0;
            MATCH_OR: hit = |(~(p ^ cc.value) & cc.mask);
            MATCH_CMP: hit = (p >= lo) && (p <= hi);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] post_target(input logic [1:0] sel);
        logic [7:0] t;
        case (sel)
            2'h1: t = 8'((`ETA_DEPTH * `ETA_POST_PCT_MID + 50) / 100);
            2'h2: t = 8'((`ETA_DEPTH * `ETA_POST_PCT_HI + 50) / 100);
            default: t = 8'((`ETA_DEPTH * `ETA_POST_PCT_LO + 50) / 100);
        endcase
        return t;
    endfunction

    logic rise;
    logic [`ETA_PW-1:0] smp;
    logic continuous;
    logic store;
    logic go_off;
    logic last_lvl;
    logic hit_lvl;
    logic hit_seg;

    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;
        go_off = 1'b0;
        store = 1'b0;
        // Edge found only from settled stages; first stage never decoded
        state_next.clk_s1 = samp_clk_i;
        state_next.clk_s2 = state_reg.clk_s1;
        state_next.clk_s3 = state_reg.clk_s2;
        // Probes assumed stable around the sampling edge, so bitwise sync is safe
        state_next.prb_s1 = probe_i;
        state_next.prb_s2 = state_reg.prb_s1;
        rise = state_reg.clk_s2 & ~state_reg.clk_s3;
        smp = state_reg.prb_s2;

        continuous = ~state_reg.cfg.qual_en | state_reg.cfg.qual_disable;
        hit_lvl = cond_hit(state_reg.cond[state_reg.lvl], state_reg.cfg.match_mode, smp,
                           state_reg.cmp_lo, state_reg.cmp_hi);
        hit_seg = cond_hit(state_reg.cond[0], state_reg.cfg.match_mode, smp,
                           state_reg.cmp_lo, state_reg.cmp_hi);
        last_lvl = state_reg.lvl == state_reg.cfg.levels_m1;

        if (rise) begin
            case (state_reg.phase)
                PH_WAIT_CLK: begin
                    if (state_reg.cfg.segmented) begin
                        state_next.phase = state_reg.cfg.plain_path_flag ? PH_SEG_PLAIN : PH_SEG_ARM;
                    end else if (continuous) begin
                        state_next.phase = PH_PRE_FILL;
                    end else begin
                        state_next.phase = state_reg.cfg.trig_in_en ? PH_TRIG_IN : PH_WAIT_TRIG;
                    end
                end
                PH_PRE_FILL: begin
                    store = 1'b1;
                    if (state_reg.fill == (`ETA_AW+1)'(`ETA_DEPTH - 1)) begin
                        state_next.phase = state_reg.cfg.trig_in_en ? PH_TRIG_IN : PH_WAIT_TRIG;
                    end
                end
                PH_TRIG_IN: begin
                    store = continuous | cond_hit(state_reg.cond[`ETA_COND_QUAL], state_reg.cfg.match_mode,
                                                  smp, state_reg.cmp_lo, state_reg.cmp_hi);
                    if (cond_hit(state_reg.cond[`ETA_COND_TRIG_IN], state_reg.cfg.match_mode, smp,
                                 state_reg.cmp_lo, state_reg.cmp_hi)) begin
                        state_next.phase = PH_WAIT_TRIG;
                    end
                end
                PH_WAIT_TRIG: begin
                    store = continuous | cond_hit(state_reg.cond[`ETA_COND_QUAL], state_reg.cfg.match_mode,
                                                  smp, state_reg.cmp_lo, state_reg.cmp_hi);
                    if (hit_lvl) begin
                        state_next.last_level = {1'b0, state_reg.lvl} + 3'h1;
                        if (last_lvl) begin
                            state_next.phase = PH_POST;
                            state_next.post_cnt = '0;
                            state_next.post_tgt = post_target(state_reg.cfg.post_sel);
                        end else begin
                            state_next.lvl = state_reg.lvl + 2'h1;
                        end
                    end
                end
                PH_POST: begin
                    store = continuous | cond_hit(state_reg.cond[`ETA_COND_QUAL], state_reg.cfg.match_mode,
                                                  smp, state_reg.cmp_lo, state_reg.cmp_hi);
                    if (store) begin
                        state_next.post_cnt = state_reg.post_cnt + 8'h01;
                    end
                    if (state_reg.post_cnt >= state_reg.post_tgt) begin
                        store = 1'b0;
                        go_off = 1'b1;
                    end
                end
                PH_SEG_PLAIN: begin
                    if (state_reg.cfg.plain_path_flag && cond_hit(state_reg.cond[`ETA_COND_PLAIN],
                            state_reg.cfg.match_mode, smp, state_reg.cmp_lo, state_reg.cmp_hi)) begin
                        store = 1'b1;
                        state_next.phase = PH_SEG_FINAL;
                        state_next.post_cnt = '0;
                        state_next.post_tgt = state_reg.seg_n - 8'h01;
                    end else if (!state_reg.cfg.plain_path_flag) begin
                        state_next.phase = PH_SEG_ARM;
                    end
                end
                PH_SEG_ARM: begin
                    if (state_reg.segment_counter > state_reg.seg_m) begin
                        store = 1'b1; // last segment triggers with n-1 more
                        state_next.phase = PH_SEG_FINAL;
                        state_next.post_cnt = '0;
                        state_next.post_tgt = state_reg.seg_n - 8'h01;
                    end else if (hit_seg && state_reg.cfg.segmented_path_flag) begin
                        store = 1'b1;
                        state_next.segment_counter = state_reg.segment_counter + 8'h01;
                        state_next.per_segment_sample_counter = 8'h01;
                        state_next.phase = PH_SEG_COUNT;
                    end
                end
                PH_SEG_COUNT: begin
                    if (state_reg.per_segment_sample_counter >= state_reg.seg_n) begin
                        state_next.per_segment_sample_counter = '0;
                        state_next.phase = state_reg.cfg.plain_path_flag ? PH_SEG_PLAIN : PH_SEG_ARM;
                    end else begin
                        store = 1'b1;
                        state_next.per_segment_sample_counter = state_reg.per_segment_sample_counter + 8'h01;
                    end
                end
                PH_SEG_FINAL: begin
                    if (state_reg.post_cnt >= state_reg.post_tgt) begin
                        go_off = 1'b1;
                    end else begin
                        store = 1'b1;
                        state_next.post_cnt = state_reg.post_cnt + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end

        if (store) begin
            state_next.mem[state_reg.wptr] = smp;
            state_next.wptr = state_reg.wptr + `ETA_AW'(1);
            if (state_reg.wptr == `ETA_AW'(`ETA_DEPTH - 1)) begin
                state_next.full = 1'b1;
            end
            if (!state_reg.fill[`ETA_AW]) begin
                state_next.fill = state_reg.fill + (`ETA_AW+1)'(1);
            end
        end

        if (wr_i) begin
            case (addr_i)
                `ETA_REG_CFG: state_next.cfg = cfg_t'(wr_data_i[`ETA_CFG_W-1:0]);
                `ETA_REG_CMP_LO: state_next.cmp_lo = wr_data_i[`ETA_PW-1:0];
                `ETA_REG_CMP_HI: state_next.cmp_hi = wr_data_i[`ETA_PW-1:0];
                `ETA_REG_SEG: begin
                    state_next.seg_m = wr_data_i[7:0];
                    state_next.seg_n = wr_data_i[15:8];
                end
                `ETA_REG_CTRL: begin
                    if (wr_data_i[`ETA_CTRL_FORCE] && state_reg.phase != PH_READY
                            && state_reg.phase != PH_OFFLOAD) begin
                        go_off = 1'b1;
                    end
                end
                default: begin
                    if (addr_i >= `ETA_REG_COND0 && addr_i < `ETA_REG_COND0 + `ETA_BUS_AW'(`ETA_NCOND)) begin
                        state_next.cond[3'(addr_i - `ETA_REG_COND0)] = wr_data_i[15:0];
                    end
                end
            endcase
        end

        if (go_off) begin
            state_next.phase = PH_OFFLOAD;
            state_next.rd_ptr = state_next.full ? state_next.wptr : '0;
            state_next.rd_left = state_next.full ? (`ETA_AW+1)'(`ETA_DEPTH) : {1'b0, state_next.wptr};
            if (!state_next.full && state_next.wptr == '0) begin
                state_next.phase = PH_READY;
            end
        end

        if (rd_i) begin
            case (addr_i)
                `ETA_REG_CTRL: state_next.rdata = '0;
                `ETA_REG_CFG: state_next.rdata = `ETA_BUS_DW'(state_reg.cfg);
                `ETA_REG_CMP_LO: state_next.rdata = `ETA_BUS_DW'(state_reg.cmp_lo);
                `ETA_REG_CMP_HI: state_next.rdata = `ETA_BUS_DW'(state_reg.cmp_hi);
                `ETA_REG_SEG: state_next.rdata = `ETA_BUS_DW'({state_reg.seg_n, state_reg.seg_m});
                `ETA_REG_STATUS: begin
                    state_next.rdata = `ETA_BUS_DW'({state_reg.rd_left, state_reg.wptr, state_reg.full,
                                                     state_reg.pu, state_reg.last_level,
                                                     state_reg.phase});
                end
                `ETA_REG_DATA: begin
                    if (state_reg.phase == PH_OFFLOAD) begin
                        state_next.rdata = `ETA_BUS_DW'(state_reg.mem[state_reg.rd_ptr]);
                        state_next.rd_ptr = state_reg.rd_ptr + `ETA_AW'(1);
                        state_next.rd_left = state_reg.rd_left - (`ETA_AW+1)'(1);
                        if (state_reg.rd_left == (`ETA_AW+1)'(1)) begin
                            state_next.phase = PH_READY;
                        end
                    end
                end
                default: begin
                    if (addr_i >= `ETA_REG_COND0 && addr_i < `ETA_REG_COND0 + `ETA_BUS_AW'(`ETA_NCOND)) begin
                        state_next.rdata = `ETA_BUS_DW'(state_reg.cond[3'(addr_i - `ETA_REG_COND0)]);
                    end
                end
            endcase
        end

        // Abort, else start, wins over any other phase change in the same cycle
        if (wr_i && addr_i == `ETA_REG_CTRL) begin
            if (wr_data_i[`ETA_CTRL_ABORT]) begin
                state_next.phase = PH_READY;
            end else if (wr_data_i[`ETA_CTRL_START]) begin
                state_next.phase = PH_WAIT_CLK;
                state_next.pu = state_next.cfg.power_up;
                state_next.lvl = '0;
                state_next.last_level = '0;
                state_next.wptr = '0;
                state_next.full = 1'b0;
                state_next.fill = '0;
                state_next.post_cnt = '0;
                state_next.segment_counter = 8'h01;
                state_next.per_segment_sample_counter = '0;
                state_next.rd_left = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.cfg <= cfg_t'(`ETA_CFG_RST);
            state_reg.seg_m <= `ETA_SEG_M_RST;
            state_reg.seg_n <= `ETA_SEG_N_RST;
            state_reg.phase <= PH_READY;
            rd_data_o <= '0;
            phase_o <= 4'h0;
            offload_o <= 1'b0;
            waiting_clk_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            rd_data_o <= state_next.rdata;
            phase_o <= state_next.phase;
            offload_o <= state_next.phase == PH_OFFLOAD;
            waiting_clk_o <= state_next.phase == PH_WAIT_CLK;
        end
    end

endmodule

// ==== bench/eta_chk.sv ====
/*
 * Port checker of the acquisition controller.
 * Assumes binding onto the controller; one clock domain, sampled clock is data.
 */
`timescale 1ns/100ps
`include "eta_consts.svh"

module eta_chk
    import eta_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic samp_clk_i,
    input wire logic [`ETA_PW-1:0] probe_i,
    input wire logic [`ETA_BUS_AW-1:0] addr_i,
    input wire logic [`ETA_BUS_DW-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`ETA_BUS_DW-1:0] rd_data_o,
    input wire logic [3:0] phase_o,
    input wire logic offload_o,
    input wire logic waiting_clk_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic start_w;
    assign start_w = wr_i && addr_i == `ETA_REG_CTRL && wr_data_i[`ETA_CTRL_START] && !wr_data_i[`ETA_CTRL_ABORT];

    a_offload_flag: assert property (offload_o == (phase_o == PH_OFFLOAD))
        else $error("offload flag disagrees with phase");
    a_wait_flag: assert property (waiting_clk_o == (phase_o == PH_WAIT_CLK))
        else $error("waiting flag disagrees with phase");
    a_ready_holds: assert property (phase_o == PH_READY && !start_w |=> phase_o == PH_READY)
        else $error("left ready without start");
    a_start_wait: assert property (start_w |=> phase_o == PH_WAIT_CLK)
        else $error("start did not enter wait for clock");
    // Four low cycles exceed the edge detector delay, so no edge can be pending
    a_clk_absent: assert property ((phase_o == PH_WAIT_CLK && !samp_clk_i && !wr_i) [*4]
        |=> phase_o == PH_WAIT_CLK)
        else $error("left wait for clock without a sampling edge");
    a_prefill_entry: assert property ($changed(phase_o) && phase_o == PH_PRE_FILL
        |-> $past(phase_o) == PH_WAIT_CLK)
        else $error("pre-fill entered from wrong phase");
    a_post_entry: assert property ($changed(phase_o) && phase_o == PH_POST
        |-> $past(phase_o) == PH_WAIT_TRIG)
        else $error("post fill entered before trigger levels");
    a_count_entry: assert property ($changed(phase_o) && phase_o == PH_SEG_COUNT
        |-> $past(phase_o) == PH_SEG_ARM)
        else $error("sample-count state entered from wrong phase");
    a_rd_idle: assert property (!rd_i |=> rd_data_o == '0)
        else $error("read data outside the answer cycle");
    a_status_phase: assert property (rd_i && addr_i == `ETA_REG_STATUS
        |=> rd_data_o[3:0] == $past(phase_o))
        else $error("status phase field wrong");
    a_data_refused: assert property (rd_i && addr_i == `ETA_REG_DATA && phase_o != PH_OFFLOAD
        |=> rd_data_o == '0)
        else $error("sample data outside offload");

    c_seg_count: cover property (phase_o == PH_SEG_COUNT);
    c_post: cover property (phase_o == PH_POST);
    c_offload_read: cover property (offload_o && rd_i && addr_i == `ETA_REG_DATA);
endmodule

bind embedded_trigger_acquisition_controller eta_chk i_eta_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .samp_clk_i(samp_clk_i), .probe_i(probe_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .phase_o(phase_o), .offload_o(offload_o),
    .waiting_clk_o(waiting_clk_o));

// ==== bench/eta_probe_src.sv ====
/*
 * Probed design model: a sampling clock of 320 ns and a counting probe.
 * Assumes run_i is held for whole runs; clock stands low while stopped.
 */
`timescale 1ns/100ps

module eta_probe_src (
    input wire logic run_i,
    output logic samp_clk_o,
    output logic [7:0] probe_o,
    output logic [15:0] count_o
);
    initial begin
        samp_clk_o = 1'b0;
        probe_o = 8'h00;
        count_o = 16'h0000;
    end
    // Probe moves on the falling edge so it is stable around each rise
    always begin
        wait (run_i);
        count_o = 16'h0000;
        probe_o = 8'h00;
        #7;
        while (run_i) begin
            #160 samp_clk_o = 1'b1;
            #160 samp_clk_o = 1'b0;
            count_o = count_o + 16'h0001;
            probe_o = count_o[7:0];
        end
    end
endmodule

// ==== bench/embedded_trigger_acquisition_controller_tb_top.sv ====
/*
 * Testbench of the acquisition controller over its register port.
 * Assumes eta_probe_src drives the sampling clock and probe, eta_chk is bound.
 */
`timescale 1ns/100ps
`include "eta_consts.svh"

module embedded_trigger_acquisition_controller_tb_top;
    import eta_pkg::*;
    logic sys_clk_i, rst_i, wr_i, rd_i, run, samp_clk;
    logic [3:0] addr_i;
    logic [31:0] wr_data_i, rd_data_o, st, last;
    logic [7:0] probe;
    logic [15:0] cnt;
    logic [3:0] phase_o;
    logic offload_o, waiting_clk_o;
    int fail_count, samples_checked;
    cfg_t c;

    embedded_trigger_acquisition_controller i_embedded_trigger_acquisition_controller (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .samp_clk_i(samp_clk), .probe_i(probe), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .phase_o(phase_o),
        .offload_o(offload_o), .waiting_clk_o(waiting_clk_o));
    eta_probe_src i_eta_probe_src (.run_i(run), .samp_clk_o(samp_clk), .probe_o(probe), .count_o(cnt));

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic wait_phase(input logic [3:0] p, input int limit);
        int i;
        for (i = 0; i < limit && phase_o !== p; i++) @(posedge sys_clk_i);
        #1 check({28'h0, phase_o}, {28'h0, p});
    endtask

    // Reads out every stored sample; the probe counts, one probe skipped per segment re-arm
    task automatic drain(input int exp_n, input int seg_n, output logic [31:0] lst);
        logic [31:0] d, first;
        int n, i;
        reg_rd(`ETA_REG_STATUS, st);
        n = int'(st[21:15]);
        if (exp_n >= 0) check(32'(n), 32'(exp_n));
        else check(32'(n > 0), 32'h1);
        for (i = 0; i < n; i++) begin
            reg_rd(`ETA_REG_DATA, d);
            if (i == 0) first = d;
            check(d, {24'h0, first[7:0] + 8'(i + (seg_n > 0 ? i / seg_n : 0))});
            lst = d;
        end
        #1 check({28'h0, phase_o}, {28'h0, PH_READY});
        run <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
    endtask

    task automatic run_trig(input logic [31:0] cfg, input logic [15:0] min_cnt, input logic [7:0] exp_last);
        reg_wr(`ETA_REG_CFG, cfg);
        reg_wr(`ETA_REG_CTRL, 32'h1);
        run <= 1'b1;
        wait_phase(PH_WAIT_TRIG, 400);
        wait_phase(PH_POST, 6000);
        check({31'h0, cnt >= min_cnt}, 32'h1);
        reg_rd(`ETA_REG_STATUS, st);
        check({29'h0, st[6:4]}, {30'h0, cfg[7:6]} + 32'h1);
        wait_phase(PH_OFFLOAD, 400);
        drain(-1, 0, last);
        check(last, {24'h0, exp_last});
    endtask

    initial begin
        #(40 * 40000);
        fail_count++;
        print_verdict();
    end

    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        {wr_i, rd_i, run, addr_i, wr_data_i} = '0;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        reg_rd(`ETA_REG_STATUS, st);
        check(st, 32'h0);
        reg_rd(4'h7, st);
        check(st, 32'h0);
        reg_rd(`ETA_REG_DATA, st);
        check(st, 32'h0);
        // Qualifier that would drop samples, overridden by the disable bit
        c = '0;
        {c.qual_en, c.qual_disable, c.post_sel} = 4'b1110;
        reg_wr(`ETA_REG_CFG, {18'h0, c});
        reg_wr(`ETA_REG_COND0 + 4'h5, 32'hFFEE);
        reg_wr(`ETA_REG_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk_i);
        check({31'h0, waiting_clk_o}, 32'h1);
        run <= 1'b1;
        wait_phase(PH_PRE_FILL, 40);
        repeat (240) @(posedge sys_clk_i);
        check({28'h0, phase_o}, {28'h0, PH_PRE_FILL});
        wait_phase(PH_OFFLOAD, 1500);
        drain(64, 0, last);
        // Forced stop of a power-up run in pre-fill
        c = '0;
        c.power_up = 1'b1;
        reg_wr(`ETA_REG_CFG, {18'h0, c});
        reg_wr(`ETA_REG_COND0, 32'hFFEE);
        reg_wr(`ETA_REG_CTRL, 32'h1);
        run <= 1'b1;
        wait_phase(PH_PRE_FILL, 40);
        reg_rd(`ETA_REG_STATUS, st);
        check({31'h0, st[7]}, 32'h1);
        repeat (80) @(posedge sys_clk_i);
        reg_wr(`ETA_REG_CTRL, 32'h2);
        wait_phase(PH_OFFLOAD, 10);
        drain(-1, 0, last);
        reg_wr(`ETA_REG_CTRL, 32'h2);
        #1 check({28'h0, phase_o}, {28'h0, PH_READY});
        // Trigger-in 30, then level 0 at 20, then level 1 at 12: order forces two wraps
        c = '0;
        {c.qual_en, c.trig_in_en, c.levels_m1, c.post_sel} = 6'b110101;
        reg_wr(`ETA_REG_COND0, 32'hFF14);
        reg_wr(`ETA_REG_COND0 + 4'h1, 32'hFF0C);
        reg_wr(`ETA_REG_COND0 + 4'h4, 32'hFF1E);
        reg_wr(`ETA_REG_COND0 + 4'h5, 32'h0000);
        run_trig({18'h0, c}, 16'd500, 8'd44);
        c = '0;
        c.qual_en = 1'b1;
        c.match_mode = MATCH_CMP;
        // Compare mode also qualifies storage: only probes 28h..30h are kept
        reg_wr(`ETA_REG_CMP_LO, 32'h28);
        reg_wr(`ETA_REG_CMP_HI, 32'h30);
        run_trig({18'h0, c}, 16'd40, 8'd48);
        // Segments: m=2 n=4 gives 12; m=4 n=16 gives 80, past the depth, and wraps; then plain path on even probes
        c = '0;
        {c.segmented_path_flag, c.segmented} = 2'b11;
        reg_wr(`ETA_REG_CFG, {18'h0, c});
        reg_wr(`ETA_REG_COND0, 32'h0000);
        reg_wr(`ETA_REG_COND0 + 4'h6, 32'h0100);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) reg_wr(`ETA_REG_CFG, 32'h1101);
            reg_wr(`ETA_REG_SEG, k == 0 ? 32'h0402 : 32'h1004);
            reg_wr(`ETA_REG_CTRL, 32'h1);
            run <= 1'b1;
            wait_phase(PH_OFFLOAD, 800);
            drain(k == 0 ? 12 : k == 1 ? 64 : 16, k == 0 ? 4 : 16, last);
        end
        print_verdict();
    end
endmodule
